// ---- core/mpc_regs.vh ----
/*
 * constants for the parameter commit block: tick timing, defaults, codes.
 * assumes inclusion by bare name from the core modules only.
 */
// How it works
// R1 - unit/machine params wait for power cycle
// R2 - live groups commit without power cycle
// R3 - reference offset commits after origin search
// R4 - workpiece offset commits on G51 execution
// R5 - feed params commit on next code/command
// R6 - axis count clamped per variant, default max
// R7 - default: all axes in task 1 only
// R8 - ports are brake or general, brake default
// R9 - encoder ratio 1/2/4, hand generator forces 1
// R10 - pass overlap uses accel or decel time
// R11 - fixed accel overrides pass, default off
// R12 - fixed accel ramp times scale by rate
// R13 - autoload stall raises error, discards data
// R14 - staging copy, active copy on commit
`ifndef MPC_REGS_VH
`define MPC_REGS_VH
`define MPC_RATIO_1      2'h0
`define MPC_RATIO_2      2'h1
`define MPC_RATIO_4      2'h2
`define MPC_PASS_ACC     1'h0
`define MPC_PASS_DEC     1'h1
`define MPC_SRC_HPG      1'h0
`define MPC_SRC_ENC      1'h1
`define MPC_DEF_TIMEOUT  16'h0000
`define MPC_DEF_BRAKE    4'hF
`define MPC_DEF_ACCFIX   1'h0
`define MPC_TICK_NS      1000000
`define MPC_CLK_NS       20
`define MPC_TICK_CYC     (`MPC_TICK_NS / `MPC_CLK_NS)
`endif

// ---- core/mpc_stage.v ----
/*
 * one staged parameter: a staging copy loaded on transfer, an active copy
 * loaded on the commit event. assumes write and commit are one-cycle pulses.
 */
`timescale 1ns/1ps
module mpc_stage #(
  parameter W   = 16,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // staging side
  input  wire         wr,
  input  wire [W-1:0] wdata,
  // commit side
  input  wire         commit,
  output reg  [W-1:0] active
);
  reg [W-1:0] stage_r;
  // a write in the commit cycle is forwarded so the newest value is taken
  always @(posedge sys_clk) begin
    if (rst) begin
      stage_r <= RST;
      active  <= RST;
    end else begin
      if (wr)
        stage_r <= wdata; // R14
      if (commit)
        active <= wr ? wdata : stage_r; // R14
    end
  end
endmodule

// ---- core/mpc_ramp.v ----
/*
 * fixed-acceleration ramp split: ramp time to the interpolation rate and
 * the remaining time. assumes rate <= max rate; a zero max gives zero.
 */
`timescale 1ns/1ps
module mpc_ramp #(
  parameter TW = 16,
  parameter VW = 16
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst,
  // operands
  input  wire [TW-1:0] acc_time,
  input  wire [VW-1:0] rate,
  input  wire [VW-1:0] max_rate,
  // results
  output reg  [TW-1:0] ramp_time,
  output reg  [TW-1:0] rest_time
);
  wire [TW+VW-1:0] prod_i = acc_time * rate;
  wire [VW-1:0]    diff   = (rate > max_rate) ? {VW{1'b0}} : max_rate - rate;
  wire [TW+VW-1:0] prod_j = acc_time * diff;
  wire [TW+VW-1:0] q_i    = (max_rate == 0) ? {(TW+VW){1'b0}} : prod_i / max_rate;
  wire [TW+VW-1:0] q_j    = (max_rate == 0) ? {(TW+VW){1'b0}} : prod_j / max_rate;
  // combinational divide, registered once; slow but small rates only
  always @(posedge sys_clk) begin
    if (rst) begin
      ramp_time <= {TW{1'b0}};
      rest_time <= {TW{1'b0}};
    end else begin
      ramp_time <= q_i[TW-1:0]; // R12
      rest_time <= q_j[TW-1:0]; // R12
    end
  end
endmodule

// ---- core/mpc_commit.v ----
/*
 * parameter commit logic for a multi-axis motion unit. transferred values
 * are staged and become active on their own commit events.
 * assumes all strobes are one-cycle pulses synchronous to sys_clk, and that
 * power_up_pulse fires once after the unit is powered on (after rst).
 */
`timescale 1ns/1ps
`include "mpc_regs.vh"
module mpc_commit #(
  parameter NAX      = 4,
  parameter TW       = 16,
  parameter VW       = 16,
  parameter OW       = 32,
  parameter TICK_CYC = `MPC_TICK_CYC
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst,
  // commit events
  input  wire          power_up_pulse,
  input  wire          origin_search_done,
  input  wire          g51_exec,
  input  wire          gcode_exec,
  input  wire          manual_cmd,
  input  wire          auto_mode,
  // transfer: unit-level values
  input  wire          unit_wr,
  input  wire [2:0]    axis_cnt_in,
  input  wire [15:0]   task_map_in,
  input  wire [3:0]    brake_sel_in,
  input  wire          pulse_src_in,
  input  wire [1:0]    enc_ratio_in,
  input  wire          pass_sel_in,
  input  wire          acc_fix_in,
  input  wire [15:0]   timeout_in,
  // transfer: live groups
  input  wire          ref_off_wr,
  input  wire [OW-1:0] ref_off_in,
  input  wire          wk_off_wr,
  input  wire [OW-1:0] wk_off_in,
  input  wire          feed_wr,
  input  wire [VW-1:0] max_rate_in,
  input  wire [VW-1:0] interp_rate_in,
  input  wire [TW-1:0] interp_acc_in,
  input  wire [TW-1:0] interp_dec_in,
  input  wire          live_wr,
  input  wire [15:0]   live_in,
  // autoload link
  input  wire          load_active,
  input  wire          load_data_pulse,
  input  wire          err_clear,
  // active unit settings
  output wire [2:0]    axis_cnt,
  output wire [15:0]   task_map,
  output wire [3:0]    brake_sel,
  output wire          pulse_src,
  output wire [1:0]    enc_ratio,
  output wire [3:0]    port_brake,
  // motion settings
  output wire [OW-1:0] ref_off,
  output wire [OW-1:0] wk_off,
  output wire [VW-1:0] max_rate,
  output wire [VW-1:0] interp_rate,
  output wire [TW-1:0] interp_acc,
  output wire [TW-1:0] interp_dec,
  output wire [15:0]   live_val,
  output reg  [TW-1:0] pass_overlap,
  output reg           acc_fix_on,
  output wire [TW-1:0] ramp_time,
  output wire [TW-1:0] rest_time,
  // autoload status
  output reg           load_err,
  output reg           load_discard
);
  localparam [2:0] AX_DEF = NAX[2:0];

  // variant-dependent clamp of the requested axis count
  function [2:0] clamp_ax;
    input [2:0] req;
    begin
      if (req == 3'h0 || req > AX_DEF)
        clamp_ax = AX_DEF; // R6
      else
        clamp_ax = req; // R6
    end
  endfunction

  // sync encoder ratio; hand generator forces 1
  function [1:0] eff_ratio;
    input src;
    input [1:0] r;
    begin
      if (src == `MPC_SRC_HPG || r == 2'h3)
        eff_ratio = `MPC_RATIO_1; // R9
      else
        eff_ratio = r; // R9
    end
  endfunction

  // default: every present axis in task 1, tasks 2-4 empty
  localparam [15:0] TASK_DEF = {12'h000, (4'hF >> (4 - NAX))}; // R7

  wire [15:0] timeout_act;
  wire        pass_act;
  wire        accfix_act;
  wire [2:0]  ax_raw;
  wire [1:0]  ratio_raw;
  // feed params commit on the next code in auto, next command in manual
  wire        feed_commit = auto_mode ? gcode_exec : manual_cmd; // R5

  // unit-level group: held until the next power-up event
  mpc_stage #(.W(3), .RST(AX_DEF)) u_ax (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (axis_cnt_in),
    .commit  (power_up_pulse), // R1
    .active  (ax_raw)
  );

  mpc_stage #(.W(16), .RST(TASK_DEF)) u_task (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (task_map_in),
    .commit  (power_up_pulse), // R1
    .active  (task_map)
  );

  mpc_stage #(.W(4), .RST(`MPC_DEF_BRAKE)) u_brk (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (brake_sel_in),
    .commit  (power_up_pulse), // R1
    .active  (brake_sel)
  );

  mpc_stage #(.W(1), .RST(`MPC_SRC_HPG)) u_src (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (pulse_src_in),
    .commit  (power_up_pulse), // R1
    .active  (pulse_src)
  );

  mpc_stage #(.W(2), .RST(`MPC_RATIO_1)) u_rat (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (enc_ratio_in),
    .commit  (power_up_pulse), // R1
    .active  (ratio_raw)
  );

  mpc_stage #(.W(1), .RST(`MPC_PASS_ACC)) u_pass (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (pass_sel_in),
    .commit  (power_up_pulse), // R1
    .active  (pass_act)
  );

  // fixed-accel mode also waits for power-up, so a live run never flips it
  mpc_stage #(.W(1), .RST(`MPC_DEF_ACCFIX)) u_afx (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (acc_fix_in),
    .commit  (power_up_pulse), // R11
    .active  (accfix_act)
  );

  mpc_stage #(.W(16), .RST(`MPC_DEF_TIMEOUT)) u_tmo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (unit_wr),
    .wdata   (timeout_in),
    .commit  (power_up_pulse), // R1
    .active  (timeout_act)
  );

  assign axis_cnt   = clamp_ax(ax_raw); // R6
  assign enc_ratio  = eff_ratio(pulse_src, ratio_raw); // R9
  // ports beyond the axis count have no axis and fall back to general use
  assign port_brake = brake_sel & (4'hF >> (3'h4 - axis_cnt)); // R8

  // live groups: no power cycle needed, each on its own event
  mpc_stage #(.W(OW)) u_ref (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (ref_off_wr),
    .wdata   (ref_off_in),
    .commit  (origin_search_done), // R3
    .active  (ref_off)
  );

  mpc_stage #(.W(OW)) u_wk (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (wk_off_wr),
    .wdata   (wk_off_in),
    .commit  (g51_exec), // R4
    .active  (wk_off)
  );

  // all four feed values share one commit so a move never mixes old and new
  mpc_stage #(.W(VW)) u_mx (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (feed_wr),
    .wdata   (max_rate_in),
    .commit  (feed_commit), // R5
    .active  (max_rate)
  );

  mpc_stage #(.W(VW)) u_ir (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (feed_wr),
    .wdata   (interp_rate_in),
    .commit  (feed_commit), // R5
    .active  (interp_rate)
  );

  mpc_stage #(.W(TW)) u_ia (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (feed_wr),
    .wdata   (interp_acc_in),
    .commit  (feed_commit), // R5
    .active  (interp_acc)
  );

  mpc_stage #(.W(TW)) u_id (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (feed_wr),
    .wdata   (interp_dec_in),
    .commit  (feed_commit), // R5
    .active  (interp_dec)
  );

  // memory, zone, servo and other values: valid immediately
  mpc_stage #(.W(16)) u_live (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr      (live_wr),
    .wdata   (live_in),
    .commit  (live_wr), // R2
    .active  (live_val)
  );

  mpc_ramp #(.TW(TW), .VW(VW)) u_ramp (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .acc_time  (interp_acc),
    .rate      (interp_rate),
    .max_rate  (max_rate),
    .ramp_time (ramp_time),
    .rest_time (rest_time)); // R12

  // pass overlap; fixed accel takes priority and zeroes the pass overlap
  always @(posedge sys_clk) begin
    if (rst) begin
      pass_overlap <= {TW{1'b0}};
      acc_fix_on   <= 1'b0;
    end else begin
      acc_fix_on <= accfix_act; // R11
      if (accfix_act)
        pass_overlap <= {TW{1'b0}}; // R11
      else if (pass_act == `MPC_PASS_DEC)
        pass_overlap <= interp_dec; // R10
      else
        pass_overlap <= interp_acc; // R10
    end
  end

  // autoload watchdog in 1 ms ticks; timeout 0 disables monitoring
  reg [31:0] tick_r;
  reg [15:0] ms_r;
  wire       tick  = (tick_r == TICK_CYC - 1);
  wire       stall = load_active && (timeout_act != 16'h0000) && (ms_r >= timeout_act);
  always @(posedge sys_clk) begin
    if (rst) begin
      tick_r       <= 32'h00000000;
      ms_r         <= 16'h0000;
      load_err     <= 1'b0;
      load_discard <= 1'b0;
    end else begin
      load_discard <= 1'b0;
      if (!load_active || load_data_pulse) begin
        tick_r <= 32'h00000000;
        ms_r   <= 16'h0000;
      end else if (!stall) begin
        tick_r <= tick ? 32'h00000000 : tick_r + 32'h00000001;
        if (tick)
          ms_r <= ms_r + 16'h0001;
      end
      // raise once per stall; set wins over clear
      if (stall && !load_err) begin
        load_err     <= 1'b1; // R13
        load_discard <= 1'b1; // R13
      end else if (err_clear && !stall) begin
        load_err <= 1'b0;
      end
    end
  end
endmodule

// ---- dv/mpc_host.sv ----
/*
 host side of the autoload link: raises load_active and sends data pulses.
 assumes the bench calls send() and supplies sys_clk.
*/
`timescale 1ns/1ps
module mpc_host (
  // clock
  input  wire logic sys_clk,
  // autoload link
  output logic      load_active,
  output logic      load_data_pulse
);
  // link idle at start
  initial begin
    load_active = 1'h0;
    load_data_pulse = 1'h0;
  end
  // one load: n pulses, each after gap idle cycles; a long gap is a stall
  task automatic send(input int n, input int gap);
    @(posedge sys_clk);
    load_active <= 1'h1;
    repeat (n) begin
      repeat (gap) @(posedge sys_clk);
      load_data_pulse <= 1'h1;
      @(posedge sys_clk);
      load_data_pulse <= 1'h0;
    end
    @(posedge sys_clk);
    load_active <= 1'h0;
    @(posedge sys_clk);
    #1;
  endtask
endmodule

// ---- dv/mpc_commit_properties.sv ----
/*
 checker for the commit block: hold, clamp, ramp and autoload relations.
 assumes it is bound onto mpc_commit and sees only its ports.
*/
`timescale 1ns/1ps
module mpc_commit_properties #(
  parameter NAX = 4, TW = 16, VW = 16, OW = 32
) (
  // clock, reset and events
  input wire logic          sys_clk, rst, power_up_pulse, origin_search_done,
  input wire logic          gcode_exec, manual_cmd, auto_mode, live_wr,
  input wire logic [15:0]   live_in, live_val,
  // settings
  input wire logic [2:0]    axis_cnt,
  input wire logic [3:0]    brake_sel,
  input wire logic          pulse_src, acc_fix_on, load_err, load_discard,
  input wire logic [1:0]    enc_ratio,
  input wire logic [OW-1:0] ref_off,
  input wire logic [VW-1:0] max_rate, interp_rate,
  input wire logic [TW-1:0] interp_acc, pass_overlap, ramp_time
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  unit_hold_a: assert property (!$past(power_up_pulse) && !$past(rst) |-> $stable(brake_sel))
    else $error("unit setting moved without power cycle");
  ref_hold_a: assert property (!$past(origin_search_done) && !$past(rst) |-> $stable(ref_off))
    else $error("reference offset moved without origin search");
  feed_hold_a: assert property (!$past(auto_mode ? gcode_exec : manual_cmd) && !$past(rst)
    |-> $stable(max_rate))
    else $error("feed rate moved without code or command");
  axis_range_a: assert property (axis_cnt >= 3'h1 && axis_cnt <= NAX)
    else $error("axis count out of range");
  hpg_ratio_a: assert property (!pulse_src |-> enc_ratio == 2'h0)
    else $error("ratio not forced to one");
  fix_pass_a: assert property (acc_fix_on && $past(acc_fix_on) |-> pass_overlap == '0)
    else $error("pass overlap kept under fixed accel");
  ramp_calc_a: assert property ($stable(interp_acc) && $stable(interp_rate)
    && $stable(max_rate) && max_rate != '0
    |-> ramp_time == TW'((32'(interp_acc) * interp_rate) / max_rate))
    else $error("ramp time wrong");
  err_pulse_a: assert property ($rose(load_err) |-> load_discard)
    else $error("stall error without discard");
  live_now_a: assert property (live_wr |=> live_val == $past(live_in))
    else $error("live value not taken at once");
  // main scenarios
  commit_c: cover property (power_up_pulse ##1 1'h1);
  discard_c: cover property (load_discard);
  origin_c: cover property (origin_search_done ##1 1'h1);
endmodule
bind mpc_commit mpc_commit_properties #(.NAX(NAX), .TW(TW), .VW(VW), .OW(OW)) chk_u (.*);

// ---- dv/mpc_commit_tb.sv ----
/*
 bench for the commit block: commit events, unit settings, autoload stall.
 assumes mpc_commit, the host model and the bound checker.
*/
`timescale 1ns/1ps
module mpc_commit_tb;
  logic        sys_clk, rst, auto_mode, pulse_src_in, pass_sel_in, acc_fix_in;
  logic        power_up_pulse, origin_search_done, g51_exec, gcode_exec, manual_cmd;
  logic        unit_wr, ref_off_wr, wk_off_wr, feed_wr, live_wr, err_clear;
  logic        load_active, load_data_pulse, pulse_src, acc_fix_on, load_err, load_discard;
  logic [1:0]  enc_ratio_in, enc_ratio;
  logic [2:0]  axis_cnt_in, axis_cnt;
  logic [3:0]  brake_sel_in, brake_sel, port_brake, bk;
  logic [10:0] stb;
  logic [15:0] task_map_in, timeout_in, live_in, max_rate_in, interp_rate_in, fa, fd, mr;
  logic [15:0] interp_acc_in, interp_dec_in, task_map, live_val, max_rate, interp_rate;
  logic [15:0] interp_acc, interp_dec, pass_overlap, ramp_time, rest_time;
  logic [31:0] ref_off_in, wk_off_in, ref_off, wk_off, ro, wo;
  int          error_cnt = 0, checks_done = 0, cyc = 0, disc_cnt = 0;
  // one strobe vector so each event is a single shifted bit
  assign {err_clear, live_wr, feed_wr, wk_off_wr, ref_off_wr, unit_wr, manual_cmd, gcode_exec,
          g51_exec, origin_search_done, power_up_pulse} = stb;
  mpc_commit #(.TICK_CYC(4)) dut_u (.*);
  mpc_host host_u (.sys_clk, .load_active, .load_data_pulse);
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  // hang guard, run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    // discard is a one-cycle pulse, so count it as it stands
    if (load_discard)
      disc_cnt <= disc_cnt + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // pulse strobe k for one cycle, then let registered outputs settle
  task automatic ev(input int k);
    @(posedge sys_clk);
    stb <= 11'h1 << k;
    @(posedge sys_clk);
    stb <= 11'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [2:0] x_axis(input logic [2:0] a);
    return (a == 3'h0 || a > 3'h4) ? 3'h4 : a;
  endfunction
  task results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(72));
    {rst, auto_mode, pulse_src_in, pass_sel_in, acc_fix_in, stb} = 16'h8000;
    {axis_cnt_in, brake_sel_in, enc_ratio_in, task_map_in, timeout_in, live_in} = 57'h0;
    {max_rate_in, interp_rate_in, interp_acc_in, interp_dec_in, ref_off_in, wk_off_in} = 128'h0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk("axis_cnt", axis_cnt, 3'h4);
    chk("task_map", task_map, 16'h000F);
    chk("port_brake", {brake_sel, port_brake}, 8'hFF);
    chk("ratio", {pulse_src, enc_ratio}, 3'h0);
    chk("acc_fix_on", acc_fix_on, 1'h0);
    host_u.send(1, 20);
    chk("load_err off", load_err, 1'h0);
    chk("discard off", disc_cnt, 32'h0);
    $display("defaults done");
    fa = 16'($urandom);
    fd = 16'($urandom);
    mr = 16'($urandom) | 16'h8000;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      {max_rate_in, interp_rate_in, interp_acc_in, interp_dec_in} <= {mr, mr >> 1, fa, fd};
      auto_mode <= i[0];
      ev(8);
      ev(i[0] ? 4 : 3);
      chk("feed held", max_rate, i[0] ? mr + 16'h1 : 16'h0);
      ev(i[0] ? 3 : 4);
      chk("feed", max_rate, mr);
      chk("ramp_time", ramp_time, 16'((32'(fa) * (mr >> 1)) / mr));
      chk("rest_time", rest_time, 16'((32'(fa) * (mr - (mr >> 1))) / mr));
      mr = i[0] ? mr : mr - 16'h1;
    end
    $display("feed done");
    ro = $urandom;
    wo = $urandom;
    @(posedge sys_clk);
    {ref_off_in, wk_off_in, live_in} <= {ro, wo, 16'(ro)};
    ev(6);
    ev(7);
    chk("wk held", wk_off, 32'h0);
    ev(2);
    chk("ref held", ref_off, 32'h0);
    chk("wk_off", wk_off, wo);
    ev(1);
    chk("ref_off", ref_off, ro);
    ev(9);
    chk("live_val", live_val, 16'(ro));
    $display("offsets done");
    bk = 4'hF;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {brake_sel_in, pass_sel_in, task_map_in, timeout_in} <= 37'({$urandom, $urandom});
      {axis_cnt_in, pulse_src_in, enc_ratio_in, acc_fix_in} <= {i[2:0], i[2:0], i[0]};
      ev(5);
      chk("brake held", brake_sel, bk);
      ev(0);
      bk = brake_sel_in;
      chk("axis_cnt", axis_cnt, x_axis(i[2:0]));
      chk("enc_ratio", enc_ratio, (i[2] && i[1:0] != 2'h3) ? i[1:0] : 2'h0);
      chk("task_map", task_map, task_map_in);
      chk("port_brake", port_brake, bk & 4'((5'h1 << x_axis(i[2:0])) - 5'h1));
      chk("acc_fix_on", acc_fix_on, i[0]);
      chk("pass_overlap", pass_overlap, i[0] ? 16'h0 : (pass_sel_in ? fd : fa));
    end
    $display("unit done");
    @(posedge sys_clk);
    timeout_in <= 16'h0002;
    ev(5);
    ev(0);
    host_u.send(3, 2);
    chk("load_err ok", load_err, 1'h0);
    host_u.send(1, 20);
    chk("load_err stall", load_err, 1'h1);
    chk("discard", disc_cnt, 32'h1);
    ev(10);
    chk("load_err clr", load_err, 1'h0);
    $display("autoload done");
    results();
  end
endmodule
